//--- inc/dft_regs.svh
// Purpose: offsets, field positions, sizes and reset values of the register port
// Assumes: byte offsets on the 8-bit host bus, 4 address bits decoded
// Notes: definitions only
`ifndef DFT_REGS_SVH
`define DFT_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DFT_OFS_CLEAR 4'h1
`define DFT_OFS_RES_LOW 4'h2
`define DFT_OFS_RES_HIGH 4'h3
`define DFT_OFS_TIRQ_CLR 4'h6
`define DFT_OFS_CNT0 4'h8
`define DFT_OFS_CNT1 4'h9
`define DFT_OFS_CNT2 4'ha
`define DFT_OFS_CMD 4'hb

// ----------------------------------------
// command register fields
// ----------------------------------------
`define DFT_SEL_MSB 7
`define DFT_SEL_LSB 6
`define DFT_ACC_MSB 5
`define DFT_ACC_LSB 4
`define DFT_MODE_MSB 3
`define DFT_MODE_LSB 1
`define DFT_BCD_BIT 0
`define DFT_RB_NOCOUNT_BIT 5
`define DFT_RB_SEL_LSB 1
`define DFT_SEL_READBACK 2'h3

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define DFT_FIFO_DEPTH 16
`define DFT_RES_W 16
`define DFT_CONV_W 13
`define DFT_NUM_CNT 3
`define DFT_RDATA_RESET 8'h00
`define DFT_CNT_ONE 16'h0001

`endif

//--- inc/dft_pkg.sv
// Purpose: types shared by the register port and its testbench
// Assumes: dft_regs.svh on the include path
// Notes: none
`include "dft_regs.svh"

package dft_pkg;

	// one host bus cycle, strobes one sys_clk wide
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dft_bus_req_t;

	typedef enum logic [1:0] {
		DFT_ACC_LATCH,
		DFT_ACC_LOW,
		DFT_ACC_HIGH,
		DFT_ACC_BOTH
	} dft_access_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic [15:0] latch;
		logic latched;
		logic running;
		logic [2:0] mode;
		logic bcd;
		dft_access_t access;
		logic wr_high;
		logic rd_high;
		logic [7:0] wr_low;
	} dft_counter_t;

endpackage

//--- hdl/dft_fifo.sv
// Purpose: show-ahead fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: flush wins over push and pop in the same cycle
`timescale 1ns/1ns
`default_nettype none

module dft_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [CW-1:0] count, next_count;
	logic next_in_ready, next_out_valid, push, pop;

	// ----------------------------------------
	// pointers and flags
	// ----------------------------------------
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr + AW'(push);
		next_rd_ptr = rd_ptr + AW'(pop);
		next_count = count + CW'(push) - CW'(pop);
		if (flush) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		// flags kept as flops so the ports carry no logic
		next_in_ready = next_count != CW'(DEPTH);
		next_out_valid = next_count != '0;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= next_in_ready;
			out_valid <= next_out_valid;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push && !flush) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_data = mem[rd_ptr];

endmodule

`default_nettype wire

//--- hdl/dft_top.sv
// Purpose: host register port for result fifo readout and three interval counters
// Assumes: host strobes are synchronous to sys_clk, one cycle wide, byte wide
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "dft_regs.svh"

module dft_top
	import dft_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire dft_bus_req_t io_req,
	output logic [7:0] io_rdata,
	input wire logic conv_valid,
	input wire logic [`DFT_CONV_W-1:0] conv_data,
	output logic conv_ready,
	output logic conv_start,
	output logic timer_irq,
	output logic result_ready_flag,
	output logic overflow_flag
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	dft_counter_t cnt [`DFT_NUM_CNT];
	dft_counter_t next_cnt [`DFT_NUM_CNT];
	logic [`DFT_NUM_CNT-1:0] tc;
	logic [7:0] next_rdata, hold_high, next_hold_high;
	logic pair_pending, next_pair_pending;
	logic next_overflow, next_irq, next_conv_start;
	logic fifo_flush, fifo_pop, fifo_valid;
	logic [`DFT_RES_W-1:0] fifo_head, conv_word;
	logic wr_clear, wr_tirq, wr_cmd, wr_cnt, rd_cnt, rd_low, rd_high;
	logic [1:0] ci;

	// ----------------------------------------
	// decode, single byte accesses only
	// ----------------------------------------
	assign wr_clear = io_req.wr && io_req.addr == `DFT_OFS_CLEAR;
	assign wr_tirq = io_req.wr && io_req.addr == `DFT_OFS_TIRQ_CLR;
	assign wr_cmd = io_req.wr && io_req.addr == `DFT_OFS_CMD;
	assign wr_cnt = io_req.wr && io_req.addr inside {`DFT_OFS_CNT0, `DFT_OFS_CNT1, `DFT_OFS_CNT2};
	assign rd_cnt = io_req.rd && io_req.addr inside {`DFT_OFS_CNT0, `DFT_OFS_CNT1, `DFT_OFS_CNT2};
	assign rd_low = io_req.rd && io_req.addr == `DFT_OFS_RES_LOW;
	assign rd_high = io_req.rd && io_req.addr == `DFT_OFS_RES_HIGH;
	assign ci = io_req.addr[1:0];

	// sign copies in bits 15-13 keep results inside -4096..+4095
	assign conv_word = {{(`DFT_RES_W-`DFT_CONV_W){conv_data[`DFT_CONV_W-1]}}, conv_data};

	// ----------------------------------------
	// result fifo
	// ----------------------------------------
	dft_fifo #(
		.WIDTH(`DFT_RES_W),
		.DEPTH(`DFT_FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.flush(fifo_flush),
		.in_valid(conv_valid),
		.in_ready(conv_ready),
		.in_data(conv_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_head)
	);

	assign result_ready_flag = fifo_valid;

	// ----------------------------------------
	// counter helpers
	// ----------------------------------------
	function automatic logic [15:0] dft_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic borrow;
		r = v - 16'h0001;
		borrow = 1'b1;
		if (bcd) begin
			r = v;
			for (int k = 0; k < 4; k++) begin
				if (borrow) begin
					if (r[k*4 +: 4] == 4'h0) begin
						r[k*4 +: 4] = 4'h9;
					end else begin
						r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	function automatic dft_counter_t dft_load(input dft_counter_t c, input logic [15:0] v);
		dft_counter_t r;
		r = c;
		r.reload = v;
		r.count = v;
		r.running = 1'b1;
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] src;
		src = '0;
		next_cnt = cnt;
		tc = '0;
		next_rdata = `DFT_RDATA_RESET;
		next_hold_high = hold_high;
		next_pair_pending = pair_pending;
		fifo_pop = 1'b0;
		fifo_flush = wr_clear;

		// countdown; no gate input, so modes 1 and 5 act as one-shots
		for (int i = 0; i < `DFT_NUM_CNT; i++) begin
			if (cnt[i].running) begin
				if (cnt[i].count == `DFT_CNT_ONE) begin
					tc[i] = 1'b1;
					if (cnt[i].mode[1]) begin
						next_cnt[i].count = cnt[i].reload;
					end else begin
						next_cnt[i].running = 1'b0;
					end
				end else begin
					next_cnt[i].count = dft_dec(cnt[i].count, cnt[i].bcd);
				end
			end
		end

		if (wr_cmd) begin
			if (io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB] == `DFT_SEL_READBACK) begin
				for (int j = 0; j < `DFT_NUM_CNT; j++) begin
					if (io_req.wdata[`DFT_RB_SEL_LSB + j] && !io_req.wdata[`DFT_RB_NOCOUNT_BIT]
						&& !cnt[j].latched) begin
						next_cnt[j].latch = cnt[j].count;
						next_cnt[j].latched = 1'b1;
					end
				end
			end else if (dft_access_t'(io_req.wdata[`DFT_ACC_MSB:`DFT_ACC_LSB]) == DFT_ACC_LATCH) begin
				if (!cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].latched) begin
					next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].latch =
						cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].count;
					next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].latched = 1'b1;
				end
			end else begin
				// a new mode halts the counter until its count is loaded
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].mode =
					io_req.wdata[`DFT_MODE_MSB:`DFT_MODE_LSB];
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].bcd = io_req.wdata[`DFT_BCD_BIT];
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].access =
					dft_access_t'(io_req.wdata[`DFT_ACC_MSB:`DFT_ACC_LSB]);
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].running = 1'b0;
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].wr_high = 1'b0;
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].rd_high = 1'b0;
				next_cnt[io_req.wdata[`DFT_SEL_MSB:`DFT_SEL_LSB]].latched = 1'b0;
			end
		end

		if (wr_cnt) begin
			unique case (cnt[ci].access)
				DFT_ACC_LOW: next_cnt[ci] = dft_load(next_cnt[ci], {8'h00, io_req.wdata});
				DFT_ACC_HIGH: next_cnt[ci] = dft_load(next_cnt[ci], {io_req.wdata, 8'h00});
				DFT_ACC_BOTH: begin
					if (cnt[ci].wr_high) begin
						next_cnt[ci] = dft_load(next_cnt[ci], {io_req.wdata, cnt[ci].wr_low});
						next_cnt[ci].wr_high = 1'b0;
					end else begin
						next_cnt[ci].wr_low = io_req.wdata;
						next_cnt[ci].wr_high = 1'b1;
						next_cnt[ci].running = 1'b0;
					end
				end
				DFT_ACC_LATCH: next_cnt[ci] = dft_load(next_cnt[ci], {8'h00, io_req.wdata});
			endcase
		end

		if (rd_cnt) begin
			src = cnt[ci].latched ? cnt[ci].latch : cnt[ci].count;
			unique case (cnt[ci].access)
				DFT_ACC_HIGH: begin
					next_rdata = src[15:8];
					next_cnt[ci].latched = 1'b0;
				end
				DFT_ACC_BOTH: begin
					next_rdata = cnt[ci].rd_high ? src[15:8] : src[7:0];
					next_cnt[ci].rd_high = !cnt[ci].rd_high;
					if (cnt[ci].rd_high) begin
						next_cnt[ci].latched = 1'b0;
					end
				end
				DFT_ACC_LOW, DFT_ACC_LATCH: begin
					next_rdata = src[7:0];
					next_cnt[ci].latched = 1'b0;
				end
			endcase
		end

		// the high half is held at the low read so the pair stays one entry
		if (rd_low) begin
			next_rdata = fifo_head[7:0];
			next_hold_high = fifo_head[15:8];
			next_pair_pending = 1'b1;
		end
		if (rd_high) begin
			next_rdata = hold_high;
			if (pair_pending) begin
				fifo_pop = fifo_valid;
				next_pair_pending = 1'b0;
			end
		end
		if (wr_clear) begin
			next_pair_pending = 1'b0;
		end

		// set wins over clear on both flags
		next_overflow = (overflow_flag && !wr_clear) || (conv_valid && !conv_ready);
		next_irq = tc[2] || (timer_irq && !wr_tirq);
		next_conv_start = tc[0] && !wr_clear;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < `DFT_NUM_CNT; i++) begin
				cnt[i] <= '0;
			end
			io_rdata <= `DFT_RDATA_RESET;
			hold_high <= `DFT_RDATA_RESET;
			pair_pending <= 1'b0;
			overflow_flag <= 1'b0;
			timer_irq <= 1'b0;
			conv_start <= 1'b0;
		end else begin
			cnt <= next_cnt;
			io_rdata <= next_rdata;
			hold_high <= next_hold_high;
			pair_pending <= next_pair_pending;
			overflow_flag <= next_overflow;
			timer_irq <= next_irq;
			conv_start <= next_conv_start;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence low_read_s;
		rd_low && !rd_high && !wr_clear;
	endsequence

	sequence high_read_s;
		rd_high && !wr_clear && fifo_valid;
	endsequence

	clear_empties_fifo_a: assert property (wr_clear |=> !result_ready_flag) else $error("fifo not empty after clear");
	clear_drops_error_a: assert property (wr_clear && conv_ready |=> !overflow_flag) else $error("overflow kept after clear");
	overflow_sets_a: assert property (conv_valid && !conv_ready |=> overflow_flag[*2] or (overflow_flag ##1 1'b1)) else $error("overflow not flagged");
	push_shows_ready_a: assert property (conv_valid && conv_ready && !wr_clear |=> result_ready_flag) else $error("ready flag missing after push");
	pair_pops_once_a: assert property (low_read_s ##1 (!io_req.rd && !wr_clear)[*1] ##1 high_read_s |-> fifo_pop ##1 !pair_pending) else $error("pair did not pop once");
	low_read_keeps_a: assert property (rd_low |-> !fifo_pop) else $error("low byte read popped fifo");
	high_sign_copies_a: assert property (low_read_s ##2 high_read_s |=> io_rdata[7:4] == {4{io_rdata[4]}}) else $error("high byte sign copies differ");
	irq_clear_works_a: assert property (wr_tirq && !tc[2] |=> !timer_irq) else $error("timer request not cleared");
	irq_set_wins_a: assert property (tc[2] |=> timer_irq) else $error("timer request lost");
	latch_holds_a: assert property (wr_cmd && io_req.wdata[7:4] == 4'h4 && !cnt[1].latched && !rd_cnt |=> cnt[1].latched && cnt[1].latch == $past(cnt[1].count)) else $error("latch did not capture count");
	mode_halts_a: assert property (wr_cmd && io_req.wdata[7:6] == 2'h1 && io_req.wdata[5:4] != 2'h0 |=> !cnt[1].running) else $error("mode write left counter running");
	pace_pulse_a: assert property (tc[0] && !wr_clear |=> conv_start ##1 (!conv_start || $past(tc[0]))) else $error("pacing pulse wrong");

endmodule

`default_nettype wire

//--- verif/dft_conv_model.sv
// Purpose: converter model offering results on the stream input
// Assumes: bench raises req for one cycle per result
// Notes: slow adds one cycle; data is scrambled while idle
`timescale 1ns/1ns
`default_nettype none

module dft_conv_model (
	input wire logic sys_clk,
	input wire logic req,
	input wire logic slow,
	input wire logic [12:0] req_data,
	output logic conv_valid,
	output logic [12:0] conv_data
);
	// ---
	// request pipe
	// ---
	logic [1:0] pend;
	logic [12:0] hold0, hold1;
	logic fire;
	initial begin
		pend = '0;
		conv_valid = 1'b0;
		conv_data = 13'h0000;
	end
	always @(posedge sys_clk) begin
		pend <= {pend[0], req};
		hold0 <= req_data;
		hold1 <= hold0;
	end
	// fire-and-forget: a result is never held for the fifo
	always @(negedge sys_clk) begin
		fire = slow ? pend[1] : pend[0];
		conv_valid <= fire;
		conv_data <= fire ? (slow ? hold1 : hold0) : ~conv_data;
	end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for dft_top
// Assumes: converter model dft_conv_model
// Notes: read bytes are checked one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none

module testbench
	import dft_pkg::*;
;
	// ---
	// signals
	// ---
	logic sys_clk, reset, conv_valid, conv_ready, conv_start, timer_irq, result_ready_flag, overflow_flag;
	logic cv_req, cv_slow, rd_d;
	logic [12:0] cv_data, conv_data;
	logic [7:0] io_rdata, last_rd;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic [15:0] seed, v;
	logic [15:0] w[17];
	logic [3:0] wo[5] = '{4'h0, 4'h1, 4'h6, 4'hb, 4'hf};
	dft_bus_req_t io_req;
	int fail_count, checks_done, n, t0;

	dft_top uut (.sys_clk(sys_clk), .reset(reset), .io_req(io_req), .io_rdata(io_rdata),
		.conv_valid(conv_valid), .conv_data(conv_data), .conv_ready(conv_ready), .conv_start(conv_start),
		.timer_irq(timer_irq), .result_ready_flag(result_ready_flag), .overflow_flag(overflow_flag));
	dft_conv_model cvm (.sys_clk(sys_clk), .req(cv_req), .slow(cv_slow), .req_data(cv_data),
		.conv_valid(conv_valid), .conv_data(conv_data));

	// ---
	// helpers
	// ---
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk8(input logic [7:0] got, input logic [7:0] want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t byte %h not %h", $time, got, want);
		end
	endtask
	task automatic chk1(input logic got, input logic want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t flag %b not %b", $time, got, want);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	// two cycles per access so a strobe is never lowered and raised in one step
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [8:0] x);
		io_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
		if (!wr) exp_q.push_back(x);
		cyc(1);
		io_req = '0;
		cyc(1);
	endtask
	task automatic rdpair(input logic [3:0] a, output logic [15:0] r);
		bus(1'b0, a, 8'h00, 9'h000);
		r[7:0] = last_rd;
		bus(1'b0, a, 8'h00, 9'h000);
		r[15:8] = last_rd;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ---
	// read monitor
	// ---
	always @(posedge sys_clk) rd_d <= io_req.rd & ~reset;
	always @(negedge sys_clk) begin
		if (rd_d === 1'b1) begin
			last_rd = io_rdata;
			if (exp_q.size() == 0) begin
				chk1(1'b0, 1'b1);
			end else begin
				e = exp_q.pop_front();
				if (e[8]) chk8(io_rdata, e[7:0]);
			end
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		#3000000;
		fail_count++;
		stop_test();
	end

	// ---
	// tests
	// ---
	initial begin
		reset = 1'b1;
		io_req = '0;
		rd_d = 1'b0;
		cv_req = 1'b0;
		cv_slow = 1'b0;
		cv_data = 13'h0000;
		seed = 16'h497a;
		cyc(10);
		reset = 1'b0;
		cyc(1);
		chk1(conv_ready, 1'b1);
		chk1(result_ready_flag, 1'b0);
		chk1(overflow_flag, 1'b0);
		chk1(timer_irq, 1'b0);
		foreach (wo[i]) bus(1'b0, wo[i], 8'h00, 9'h100);
		$display("test reset done");
		for (int i = 0; i < 17; i++) begin
			seed = lfsr(seed);
			v = i == 0 ? 16'h1000 : i == 1 ? 16'h0fff : seed;
			w[i] = {{3{v[12]}}, v[12:0]};
		end
		cv_req = 1'b1;
		for (int i = 0; i < 17; i++) begin
			cv_data = w[i][12:0];
			cyc(1);
		end
		cv_req = 1'b0;
		cyc(4);
		chk1(conv_ready, 1'b0);
		chk1(overflow_flag, 1'b1);
		chk1(result_ready_flag, 1'b1);
		for (int i = 0; i < 16; i++) begin
			bus(1'b0, 4'h2, 8'h00, {1'b1, w[i][7:0]});
			bus(1'b0, 4'h3, 8'h00, {1'b1, w[i][15:8]});
			if (i == 0) bus(1'b0, 4'h3, 8'h00, {1'b1, w[0][15:8]});
			if (i == 0) chk1(conv_ready, 1'b1);
		end
		chk1(result_ready_flag, 1'b0);
		chk1(overflow_flag, 1'b1);
		$display("test fifo done");
		cv_slow = 1'b1;
		repeat (3) begin
			seed = lfsr(seed);
			cv_req = 1'b1;
			cv_data = seed[12:0];
			cyc(1);
			cv_req = 1'b0;
			cyc(3);
		end
		chk1(result_ready_flag, 1'b1);
		bus(1'b1, 4'h1, 8'hff, 9'h000);
		chk1(result_ready_flag, 1'b0);
		chk1(overflow_flag, 1'b0);
		chk1(conv_ready, 1'b1);
		bus(1'b0, 4'h2, 8'h00, 9'h000);
		bus(1'b0, 4'h3, 8'h00, 9'h000);
		chk1(result_ready_flag, 1'b0);
		$display("test clear done");
		bus(1'b1, 4'hb, 8'h34, 9'h000);
		bus(1'b1, 4'h8, 8'h06, 9'h000);
		bus(1'b1, 4'h8, 8'h00, 9'h000);
		n = 0;
		while (conv_start !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		cyc(1);
		n = 1;
		while (conv_start !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk1(n == 6, 1'b1);
		for (int m = 0; m < 6; m++) begin
			bus(1'b1, 4'hb, {4'h3, m[2:0], 1'b0}, 9'h000);
			bus(1'b1, 4'h8, 8'h04, 9'h000);
			bus(1'b1, 4'h8, 8'h00, 9'h000);
			n = 0;
			repeat (40) begin
				cyc(1);
				n += (conv_start === 1'b1);
			end
			chk1(n > 3, m[1]);
		end
		bus(1'b1, 4'hb, 8'h30, 9'h000);
		$display("test pacing done");
		bus(1'b1, 4'hb, 8'h70, 9'h000);
		bus(1'b1, 4'h9, 8'h34, 9'h000);
		t0 = $time;
		bus(1'b1, 4'h9, 8'h12, 9'h000);
		cyc(9);
		for (int k = 0; k < 2; k++) begin
			n = ($time - t0) / 100;
			bus(1'b1, 4'hb, k ? 8'hc4 : 8'h40, 9'h000);
			cyc(8);
			rdpair(4'h9, v);
			chk1(v >= 16'h1233 - n && v <= 16'h1235 - n, 1'b1);
		end
		// decimal count: 0x0010 steps to 0x0009, binary would give 0x000f
		bus(1'b1, 4'hb, 8'h71, 9'h000);
		bus(1'b1, 4'h9, 8'h10, 9'h000);
		bus(1'b1, 4'h9, 8'h00, 9'h000);
		bus(1'b1, 4'hb, 8'h40, 9'h000);
		rdpair(4'h9, v);
		chk8(v[7:0], 8'h09);
		chk8(v[15:8], 8'h00);
		$display("test latch done");
		bus(1'b1, 4'hb, 8'h94, 9'h000);
		bus(1'b1, 4'ha, 8'h05, 9'h000);
		n = 0;
		while (timer_irq !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		bus(1'b1, 4'hb, 8'h90, 9'h000);
		cyc(10);
		chk1(timer_irq, 1'b1);
		bus(1'b1, 4'h6, 8'h00, 9'h000);
		chk1(timer_irq, 1'b0);
		$display("test timer done");
		stop_test();
	end
endmodule
`default_nettype wire
